// *** shared/pnw_pkg.sv ***
// Package with register map, field layout and timing for the wake config bank.
package pnw_pkg;

  // Register offsets on the serial register port.
  localparam logic [11:0] PNW_ADDR_IRQ_EN     = 12'h010;
  localparam logic [11:0] PNW_ADDR_RATE_FILT = 12'h031;
  localparam logic [11:0] PNW_ADDR_CAN_CFG   = 12'h032;
  localparam logic [11:0] PNW_ADDR_WAKE_PULS = 12'h040;
  localparam logic [11:0] PNW_ADDR_IRQ_STAT  = 12'h060;
  localparam logic [11:0] PNW_ADDR_SOFT_RST  = 12'hFE0;

  // Reset values and writable-bit masks (reserved bits stay zero).
  localparam logic [7:0] PNW_RST_IRQ_EN     = 8'h0C;
  localparam logic [7:0] PNW_RST_RATE_FILT  = 8'h04;
  localparam logic [7:0] PNW_RST_CAN_CFG    = 8'h00;
  localparam logic [7:0] PNW_RST_WAKE_PULS  = 8'h00;
  localparam logic [7:0] PNW_RST_IRQ_STAT   = 8'h80;
  localparam logic [7:0] PNW_MASK_IRQ_EN    = 8'h7F;
  localparam logic [7:0] PNW_MASK_RATE_FILT = 8'hF7;
  localparam logic [7:0] PNW_MASK_CAN_CFG   = 8'h07;
  localparam logic [7:0] PNW_MASK_WAKE_PULS = 8'h01;
  localparam logic [7:0] PNW_SLEEP_FORCE_EN = 8'h43;

  // Field positions.
  localparam int PNW_IDLE_FILTER_SELECT_LSB  = 4;
  localparam int PNW_RATE_LSB  = 0;
  localparam int PNW_ECC_BIT   = 2;
  localparam int PNW_COK_BIT   = 1;
  localparam int PNW_SELWAKE_ENABLE_BIT  = 0;
  localparam int PNW_WFC_BIT   = 0;
  localparam int PNW_PO_BIT    = 7;

  // Soft reset key bytes.
  localparam logic [7:0] PNW_KEY_SETUP   = 8'h01;
  localparam logic [7:0] PNW_KEY_CONFIRM = 8'h80;

  // Idle filter codes and rate codes.
  localparam logic [3:0] PNW_IDLE_FILTER_SELECT_ISO2   = 4'h2;
  localparam logic [3:0] PNW_IDLE_FILTER_SELECT_ABS0   = 4'h3;
  localparam logic [3:0] PNW_IDLE_FILTER_SELECT_ABS3   = 4'h6;
  localparam logic [2:0] PNW_RATE_RSVD   = 3'h6;

  // Timing: clock period and filter detect limits.
  localparam int PNW_CLK_PS        = 4000;
  localparam int PNW_PCT_DET_STD   = 1750;  // 17.5 % in 0.01 % units.
  localparam int PNW_PCT_DET_FAST  = 875;   // 8.75 % in 0.01 % units.
  localparam int PNW_PCT_SCALE     = 10000;
  localparam int PNW_ABS_DET_NS [4] = '{93, 119, 145, 170};
  localparam int PNW_RATE_KBPS  [8] = '{50, 100, 125, 250, 500, 667, 500, 1000};

  typedef enum logic [0:0] {
    PNW_KEY_IDLE  = 1'b0,
    PNW_KEY_ARMED = 1'b1
  } pnw_key_state_type;

  // One register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } pnw_reg_req_type;

  // Accept threshold in clock cycles; longest time, so it rounds down.
  function automatic logic [11:0] pnw_detect_cycles(input logic [3:0] idle_filter_select,
                                                    input logic [2:0] rate);
    int bit_ps;
    int det_ps;
    bit_ps = 1000000000 / PNW_RATE_KBPS[rate];
    if (idle_filter_select >= PNW_IDLE_FILTER_SELECT_ABS0 && idle_filter_select <= PNW_IDLE_FILTER_SELECT_ABS3) begin
      det_ps = PNW_ABS_DET_NS[int'(idle_filter_select - PNW_IDLE_FILTER_SELECT_ABS0)] * 1000;
    end else if (idle_filter_select == PNW_IDLE_FILTER_SELECT_ISO2) begin
      det_ps = bit_ps / PNW_PCT_SCALE * PNW_PCT_DET_FAST;
    end else begin
      det_ps = bit_ps / PNW_PCT_SCALE * PNW_PCT_DET_STD;
    end
    // Stages two and three must agree before counting starts, which eats
    // one cycle of an unaligned pulse; without it a pulse just above the
    // limit could be lost.
    return 12'((det_ps / PNW_CLK_PS > 1) ? det_ps / PNW_CLK_PS - 1 : 1);
  endfunction : pnw_detect_cycles

endpackage : pnw_pkg

// *** tb/pnw_config_regs_bench.sv ***
// Self-checking bench for the wake configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module pnw_config_regs_bench
  import pnw_pkg::*;
;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            ce = 1'b1;
  logic            slp = 1'b0;
  logic            fd = 1'b0;
  logic            rx = 1'b1;
  logic            filt;
  int              lows = 0;
  logic [6:0]      evt = 7'h00;
  logic [7:0]      rdat, got, flags;
  logic            core, act, wup, err, inc, lng, srst, pend;
  pnw_reg_req_type req;
  int              errors = 0;
  int              compares = 0;
  int              pulses = 0;
  logic [11:0]     at [5] = '{12'h010, 12'h031, 12'h032, 12'h040, 12'h060};
  logic [7:0]      rt [5] = '{8'h0C, 8'h04, 8'h00, 8'h00, 8'h80};
  // Flag byte: core, active, pattern only, error, long, pending.
  assign flags = {2'b00, core, act, wup, err, lng, pend};
  always #2 clk = ~clk;
  // Soft reset pulses are counted so a missing or extra one shows.
  always @(posedge clk) if (srst === 1'b1) pulses++;
  // Any cycle with the filtered level not high counts as a passed pulse.
  always @(posedge clk) if (filt !== 1'b1) lows++;
  pnw_config_regs i_pnw_config_regs (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .REG_WR_I(req.wr),
    .REG_RD_I(req.rd), .REG_ADDR_I(req.addr), .REG_WDATA_I(req.wdata),
    .REG_RDATA_O(rdat), .IRQ_EVENT_I(evt), .SLEEP_FORCED_I(slp),
    .FD_FRAME_I(fd), .BUS_RX_I(rx), .BUS_RX_FILT_O(filt),
    .DECODE_CORE_EN_O(core), .SELWAKE_ACTIVE_O(act), .WUP_ONLY_O(wup),
    .SELWAKE_ERR_O(err), .FD_ERR_INC_O(inc), .WAKE_LONG_PULSE_O(lng),
    .SOFT_RESET_O(srst), .IRQ_PENDING_O(pend));
  pnw_host i_pnw_host (.clk_i(clk), .rdata_i(rdat), .req_o(req));
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    i_pnw_host.rd(a, got);
    chk($sformatf("reg %h", a), e, got);
  endtask : rchk
  // Write, then wait until the derived outputs have followed.
  task automatic wset(input logic [11:0] a, input logic [7:0] d);
    i_pnw_host.wr(a, d);
    i_pnw_host.idle();
    @(posedge clk);
    #1;
  endtask : wset
  task automatic ev(input logic [6:0] e, input logic s);
    @(posedge clk);
    evt <= e;
    slp <= s;
    @(posedge clk);
    evt <= 7'h00;
    slp <= 1'b0;
  endtask : ev
  task automatic fdp(input logic e);
    @(posedge clk);
    fd <= 1'b1;
    @(posedge clk);
    fd <= 1'b0;
    #1;
    chk("fd inc", {7'h00, e}, {7'h00, inc});
  endtask : fdp
  // One low pulse of n cycles on the bus pin; e says whether it must pass.
  // The long tail lets an accepted pulse recover before the next one.
  task automatic pls(input int n, input logic e);
    lows = 0;
    @(posedge clk);
    rx <= 1'b0;
    repeat (n) @(posedge clk);
    rx <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("filter", {7'h00, e}, {7'h00, lows > 0});
    repeat (100) @(posedge clk);
  endtask : pls
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // A hang is cut short and counted as a mismatch.
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(at[i], rt[i]);
    chk("flags", 8'h2D, flags);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      wset(PNW_ADDR_RATE_FILT, {i[3:0], 1'b0, i[2:0]});
      rchk(PNW_ADDR_RATE_FILT, {i[3:0], 1'b0, i[2:0]});
      chk("core", {7'h00, i[2:0] != 3'h6}, {7'h00, core});
    end
    $display("test rate and filter done");
    wset(PNW_ADDR_RATE_FILT, 8'h04);
    pls(20, 1'b0);
    pls(90, 1'b1);
    wset(PNW_ADDR_RATE_FILT, 8'h24);
    pls(10, 1'b0);
    pls(45, 1'b1);
    wset(PNW_ADDR_RATE_FILT, 8'h34);
    pls(4, 1'b0);
    pls(24, 1'b1);
    $display("test bus filter done");
    wset(PNW_ADDR_RATE_FILT, 8'h04);
    wset(PNW_ADDR_CAN_CFG, 8'h03);
    chk("flags", 8'h31, flags);
    wset(PNW_ADDR_CAN_CFG, 8'h05);
    chk("flags", 8'h2D, flags);
    fdp(1'b0);
    wset(PNW_ADDR_CAN_CFG, 8'h02);
    chk("flags", 8'h29, flags);
    fdp(1'b1);
    wset(PNW_ADDR_WAKE_PULS, 8'h01);
    rchk(PNW_ADDR_WAKE_PULS, 8'h01);
    // A write while the clock enable is low must leave everything frozen.
    @(posedge clk);
    ce <= 1'b0;
    wset(PNW_ADDR_WAKE_PULS, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rchk(PNW_ADDR_WAKE_PULS, 8'h01);
    chk("long", 8'h01, {7'h00, lng});
    $display("test wake config done");
    wset(PNW_ADDR_IRQ_STAT, 8'h80);
    rchk(PNW_ADDR_IRQ_STAT, 8'h00);
    ev(7'h43, 1'b0);
    rchk(PNW_ADDR_IRQ_STAT, 8'h00);
    ev(7'h08, 1'b0);
    wset(PNW_ADDR_IRQ_STAT, 8'h00);
    rchk(PNW_ADDR_IRQ_STAT, 8'h08);
    wset(PNW_ADDR_IRQ_STAT, 8'h08);
    chk("flags", 8'h2A, flags);
    ev(7'h00, 1'b1);
    rchk(PNW_ADDR_IRQ_EN, 8'h4F);
    $display("test interrupts done");
    i_pnw_host.key(8'h55);
    rchk(PNW_ADDR_IRQ_EN, 8'h4F);
    // A confirm byte after the aborted pair must not fire the reset.
    i_pnw_host.wr(PNW_ADDR_SOFT_RST, PNW_KEY_CONFIRM);
    i_pnw_host.idle();
    repeat (2) @(posedge clk);
    chk("pulses", 8'h00, 8'(pulses));
    i_pnw_host.key(8'h80);
    repeat (2) @(posedge clk);
    chk("pulses", 8'h01, 8'(pulses));
    for (int i = 0; i < 5; i++) rchk(at[i], rt[i]);
    rchk(PNW_ADDR_SOFT_RST, 8'h00);
    $display("test soft reset done");
    print_verdict();
  end
endmodule : pnw_config_regs_bench
`default_nettype wire

// *** tb/pnw_host.sv ***
// Host model issuing single-byte register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module pnw_host
  import pnw_pkg::*;
(
  // Clock and read data from the bank.
  input  wire logic           clk_i,
  input  wire logic [7:0]     rdata_i,
  // Request, changed only just after a rising edge.
  output var pnw_reg_req_type req_o
);
  initial req_o = '0;
  // reserved bits zero
  // Callers pass reserved bits as zero, as the bank expects.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b0, a, d};
  endtask : wr
  task automatic idle();
    @(posedge clk_i);
    req_o <= '0;
  endtask : idle
  // The byte settles just after the edge that takes the strobe.
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    idle();
    #1;
    d = rdata_i;
  endtask : rd
  task automatic key(input logic [7:0] k);
    wr(PNW_ADDR_SOFT_RST, PNW_KEY_SETUP);
    wr(PNW_ADDR_SOFT_RST, k);
    idle();
  endtask : key
endmodule : pnw_host
`default_nettype wire

// *** tb/pnw_props.sv ***
// Port-level assertions for the wake configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module pnw_props
  import pnw_pkg::*;
(
  // Clock, reset, register port and frame events.
  input wire logic        REF_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        CE_I,
  input wire logic        REG_WR_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        FD_FRAME_I,
  // Configuration and status outputs.
  input wire logic        DECODE_CORE_EN_O,
  input wire logic        SELWAKE_ACTIVE_O,
  input wire logic        WUP_ONLY_O,
  input wire logic        SELWAKE_ERR_O,
  input wire logic        FD_ERR_INC_O,
  input wire logic        WAKE_LONG_PULSE_O,
  input wire logic        SOFT_RESET_O,
  input wire logic        IRQ_PENDING_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // A frozen clock or a soft reset would spoil the latencies below.
  wire logic  wr_on  = CE_I && REG_WR_I;
  wire logic  quiet  = CE_I && !SOFT_RESET_O;
  wire logic  cfg_wr = wr_on && quiet;
  wire logic  key_wr = wr_on && REG_ADDR_I == PNW_ADDR_SOFT_RST;
  logic [7:0] last_key_reg;
  wire logic  armed  = key_wr && REG_WDATA_I == PNW_KEY_SETUP
                       && last_key_reg != PNW_KEY_SETUP;
  // A setup byte arms only when the key byte before it was not a setup.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I) last_key_reg <= 8'h00;
    else if (key_wr) last_key_reg <= REG_WDATA_I;

  a_key_confirm: assert property (
    armed ##1 key_wr && REG_WDATA_I == PNW_KEY_CONFIRM |=> SOFT_RESET_O)
    else $error("confirmed key gave no reset pulse");
  a_key_abort: assert property (
    armed ##1 key_wr && REG_WDATA_I != PNW_KEY_CONFIRM |=> !SOFT_RESET_O)
    else $error("aborted key gave a reset pulse");
  a_reset_pulse: assert property (
    SOFT_RESET_O && CE_I |=> !SOFT_RESET_O && IRQ_PENDING_O)
    else $error("reset pulse too long or power-on flag lost");
  a_fd_count: assert property (
    FD_ERR_INC_O && $past(CE_I) |-> $past(FD_FRAME_I))
    else $error("error count pulse without a frame");
  a_core_off: assert property (
    cfg_wr && REG_ADDR_I == PNW_ADDR_RATE_FILT
    && REG_WDATA_I[2:0] == PNW_RATE_RSVD ##1 quiet |=> !DECODE_CORE_EN_O)
    else $error("reserved rate left the core enabled");
  a_cfg_invalid: assert property (
    cfg_wr && REG_ADDR_I == PNW_ADDR_CAN_CFG && !REG_WDATA_I[PNW_COK_BIT]
    ##1 quiet |=> SELWAKE_ERR_O && WUP_ONLY_O && !SELWAKE_ACTIVE_O)
    else $error("invalid setup did not force pattern wake");
  a_wake_width: assert property (
    cfg_wr && REG_ADDR_I == PNW_ADDR_WAKE_PULS ##1 quiet
    |=> WAKE_LONG_PULSE_O == $past(REG_WDATA_I[PNW_WFC_BIT], 2))
    else $error("wake width output does not follow bit 0");
  a_irq_sticky: assert property (
    IRQ_PENDING_O && CE_I && !(wr_on && REG_ADDR_I == PNW_ADDR_IRQ_STAT)
    |=> IRQ_PENDING_O)
    else $error("pending interrupt dropped without a clear");
  c_soft_reset: cover property (SOFT_RESET_O);
  c_core_off: cover property (!DECODE_CORE_EN_O);
  c_fd_inc: cover property (FD_ERR_INC_O);
endmodule : pnw_props
bind pnw_config_regs pnw_props i_pnw_props (
  .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
  .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .FD_FRAME_I(FD_FRAME_I),
  .DECODE_CORE_EN_O(DECODE_CORE_EN_O),
  .SELWAKE_ACTIVE_O(SELWAKE_ACTIVE_O), .WUP_ONLY_O(WUP_ONLY_O),
  .SELWAKE_ERR_O(SELWAKE_ERR_O), .FD_ERR_INC_O(FD_ERR_INC_O),
  .WAKE_LONG_PULSE_O(WAKE_LONG_PULSE_O),
  .SOFT_RESET_O(SOFT_RESET_O), .IRQ_PENDING_O(IRQ_PENDING_O));
`default_nettype wire

// *** verilog/pnw_config_regs.sv ***
// Selective wake-up configuration register bank with bus idle filter.
`timescale 1ns/1ps
`default_nettype none

module pnw_config_regs
  import pnw_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic       REF_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       CE_I,
  // Register port from the serial interface front end.
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [11:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  // Interrupt events and sleep entry from the mode controller.
  input  wire logic [6:0] IRQ_EVENT_I,
  input  wire logic       SLEEP_FORCED_I,
  input  wire logic       FD_FRAME_I,
  // Raw receive level from the bus comparator pin.
  input  wire logic       BUS_RX_I,
  // Configuration and status outputs.
  output logic            BUS_RX_FILT_O,
  output logic            DECODE_CORE_EN_O,
  output logic            SELWAKE_ACTIVE_O,
  output logic            WUP_ONLY_O,
  output logic            SELWAKE_ERR_O,
  output logic            FD_ERR_INC_O,
  output logic            WAKE_LONG_PULSE_O,
  output logic            SOFT_RESET_O,
  output logic            IRQ_PENDING_O
);

  pnw_reg_req_type   req;
  pnw_key_state_type key_reg;
  logic [7:0]  irq_en_reg;
  logic [7:0]  rate_filt_reg;
  logic [7:0]  can_cfg_reg;
  logic [7:0]  wake_puls_reg;
  logic [7:0]  irq_stat_reg;
  logic [7:0]  irq_stat_next;
  logic [7:0]  irq_set;
  logic [7:0]  irq_clr;
  logic [2:0]  rx_sync_reg;
  logic [11:0] filt_cnt_reg;
  logic [11:0] det_cycles;
  logic        filt_level_reg;
  logic        soft_rst_req;
  logic        wr_key;

  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I,
                 wdata: REG_WDATA_I};
  assign wr_key = req.wr && req.addr == PNW_ADDR_SOFT_RST;

  // Key sequence; any other byte right after setup drops the arming.
  // two-step key
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      key_reg      <= PNW_KEY_IDLE;
      SOFT_RESET_O <= 1'b0;
    end else if (CE_I) begin
      SOFT_RESET_O <= 1'b0;
      if (wr_key) begin
        case (key_reg)
          PNW_KEY_IDLE: begin
            if (req.wdata == PNW_KEY_SETUP) key_reg <= PNW_KEY_ARMED;
          end
          PNW_KEY_ARMED: begin
            key_reg      <= PNW_KEY_IDLE;
            SOFT_RESET_O <= (req.wdata == PNW_KEY_CONFIRM);
          end
          default: key_reg <= PNW_KEY_IDLE;
        endcase
      end
    end
  end

  // A confirmed key restores the config and enable registers one cycle after the pulse; status only gains bit 7.
  assign soft_rst_req = SOFT_RESET_O;

  // Configuration registers; reserved bits are masked off on write.
  // reset defaults
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rate_filt_reg <= PNW_RST_RATE_FILT;
      can_cfg_reg   <= PNW_RST_CAN_CFG;
      wake_puls_reg <= PNW_RST_WAKE_PULS;
    end else if (CE_I) begin
      if (soft_rst_req) begin
        rate_filt_reg <= PNW_RST_RATE_FILT;
        can_cfg_reg   <= PNW_RST_CAN_CFG;
        wake_puls_reg <= PNW_RST_WAKE_PULS;
      end else if (req.wr) begin
        if (req.addr == PNW_ADDR_RATE_FILT)
          rate_filt_reg <= req.wdata & PNW_MASK_RATE_FILT;
        if (req.addr == PNW_ADDR_CAN_CFG)
          can_cfg_reg <= req.wdata & PNW_MASK_CAN_CFG;
        if (req.addr == PNW_ADDR_WAKE_PULS)
          wake_puls_reg <= req.wdata & PNW_MASK_WAKE_PULS;
      end
    end
  end

  // Interrupt enables; timer-forced sleep wins over a host write.
  // forced wake enables
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_en_reg <= PNW_RST_IRQ_EN;
    end else if (CE_I) begin
      if (soft_rst_req) begin
        irq_en_reg <= PNW_RST_IRQ_EN;
      end else if (SLEEP_FORCED_I) begin
        irq_en_reg <= irq_en_reg | PNW_SLEEP_FORCE_EN;
      end else if (req.wr && req.addr == PNW_ADDR_IRQ_EN) begin
        irq_en_reg <= req.wdata & PNW_MASK_IRQ_EN;
      end
    end
  end

  // Sticky status: enabled events set, write-one clears, set wins.
  // enable gating
  always_comb begin
    irq_set = {soft_rst_req, IRQ_EVENT_I & irq_en_reg[6:0]};
    irq_clr = (req.wr && req.addr == PNW_ADDR_IRQ_STAT) ? req.wdata : 8'h00;
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_stat_reg  <= PNW_RST_IRQ_STAT;
      IRQ_PENDING_O <= 1'b1;
    end else if (CE_I) begin
      irq_stat_reg  <= irq_stat_next;
      IRQ_PENDING_O <= |irq_stat_next;
    end
  end

  // Read port; reserved bits and the write-only key read as zero.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (CE_I && req.rd) begin
      case (req.addr)
        PNW_ADDR_IRQ_EN:     REG_RDATA_O <= irq_en_reg;
        PNW_ADDR_RATE_FILT:  REG_RDATA_O <= rate_filt_reg;
        PNW_ADDR_CAN_CFG:    REG_RDATA_O <= can_cfg_reg;
        PNW_ADDR_WAKE_PULS:  REG_RDATA_O <= wake_puls_reg;
        PNW_ADDR_IRQ_STAT:   REG_RDATA_O <= irq_stat_reg;
        default:             REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // Three-stage pin synchroniser; stages two and three must agree.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_sync_reg <= 3'b111;
    end else if (CE_I) begin
      rx_sync_reg <= {rx_sync_reg[1:0], BUS_RX_I};
    end
  end

  // Reserved filter codes fall back to the default percentage filter.
  // percent filter
  assign det_cycles = pnw_detect_cycles(rate_filt_reg[PNW_IDLE_FILTER_SELECT_LSB +: 4],
                                        rate_filt_reg[PNW_RATE_LSB +: 3]);

  // Pulses shorter than the accept threshold never move the filtered level;
  // the counter restarts whenever the pin returns to the current level.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      filt_level_reg <= 1'b1;
      filt_cnt_reg   <= 12'h000;
      BUS_RX_FILT_O  <= 1'b1;
    end else if (CE_I) begin
      if (rx_sync_reg[2] != rx_sync_reg[1]
          || rx_sync_reg[2] == filt_level_reg) begin
        filt_cnt_reg <= 12'h000;
      end else if (filt_cnt_reg + 12'h001 >= det_cycles) begin
        filt_cnt_reg   <= 12'h000;
        filt_level_reg <= rx_sync_reg[2];
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 12'h001;
      end
      BUS_RX_FILT_O <= filt_level_reg;
    end
  end

  // Derived controls for the decoding core, all registered.
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DECODE_CORE_EN_O  <= 1'b1;
      SELWAKE_ACTIVE_O  <= 1'b0;
      WUP_ONLY_O        <= 1'b1;
      SELWAKE_ERR_O     <= 1'b1;
      FD_ERR_INC_O      <= 1'b0;
      WAKE_LONG_PULSE_O <= 1'b0;
    end else if (CE_I) begin
      DECODE_CORE_EN_O <= rate_filt_reg[PNW_RATE_LSB +: 3] != PNW_RATE_RSVD;
      SELWAKE_ACTIVE_O <= can_cfg_reg[PNW_SELWAKE_ENABLE_BIT]
                          && can_cfg_reg[PNW_COK_BIT]
                          && rate_filt_reg[PNW_RATE_LSB +: 3] != PNW_RATE_RSVD;
      WUP_ONLY_O <= !(can_cfg_reg[PNW_SELWAKE_ENABLE_BIT] && can_cfg_reg[PNW_COK_BIT]);
      SELWAKE_ERR_O <= !can_cfg_reg[PNW_COK_BIT];
      FD_ERR_INC_O <= FD_FRAME_I && !can_cfg_reg[PNW_ECC_BIT];
      WAKE_LONG_PULSE_O <= wake_puls_reg[PNW_WFC_BIT];
    end
  end

endmodule : pnw_config_regs

`default_nettype wire
